// *** common/pie_pkg.sv ***
// package: register map, field layout and types of the irq enable block
package pie_pkg;

    // bus widths
    localparam int PIE_DATA_W = 32;
    localparam int PIE_ADDR_W = 12;
    localparam int PIE_REG_W  = 8;
    localparam int PIE_SRC_N  = 4;

    // register byte offsets
    localparam logic [PIE_ADDR_W-1:0] ENABLE_OFFSET = 12'h000;
    localparam logic [PIE_ADDR_W-1:0] LIVE_OFFSET   = 12'h004;
    localparam logic [PIE_ADDR_W-1:0] STATUS_OFFSET = 12'h008;
    localparam logic [PIE_ADDR_W-1:0] CLEAR_OFFSET  = 12'h00c;
    localparam logic [PIE_ADDR_W-1:0] IRQ_EN_OFFSET = 12'h010;

    // field positions inside every 8-bit register
    localparam int OSC_FAIL_BIT   = 7;
    localparam int COMPARATOR_BIT = 5;
    localparam int NVM_DONE_BIT   = 4;
    localparam int BUS_COLL_BIT   = 3;

    // implemented bits; 6 and 2..0 always read zero
    localparam logic [PIE_REG_W-1:0] IMPL_MASK = 8'hb8;

    // reset values
    localparam logic [PIE_REG_W-1:0]  ENABLE_RESET = 8'h00;
    localparam logic [PIE_REG_W-1:0]  IRQ_EN_RESET = 8'h00;
    localparam logic [PIE_DATA_W-1:0] RDATA_RESET  = 32'h0000_0000;

    // one bit per interrupt source
    typedef struct packed {
        logic osc_fail;
        logic comparator;
        logic nvm_write_done;
        logic serial_bus_collision;
    } pie_src_t;

    // register selected by an apb address
    typedef enum logic [2:0] {
        SEL_NONE   = 3'b000,
        SEL_ENABLE = 3'b001,
        SEL_LIVE   = 3'b010,
        SEL_STATUS = 3'b011,
        SEL_CLEAR  = 3'b100,
        SEL_IRQ_EN = 3'b101
    } pie_sel_t;

    // place source bits at their register positions
    function automatic logic [PIE_REG_W-1:0] src_to_reg(input pie_src_t s);
        logic [PIE_REG_W-1:0] r;
        r = '0;
        r[OSC_FAIL_BIT]   = s.osc_fail;
        r[COMPARATOR_BIT] = s.comparator;
        r[NVM_DONE_BIT]   = s.nvm_write_done;
        r[BUS_COLL_BIT]   = s.serial_bus_collision;
        return r;
    endfunction

    // pick source bits out of a register value
    function automatic pie_src_t reg_to_src(input logic [PIE_REG_W-1:0] r);
        pie_src_t s;
        s.osc_fail             = r[OSC_FAIL_BIT];
        s.comparator           = r[COMPARATOR_BIT];
        s.nvm_write_done       = r[NVM_DONE_BIT];
        s.serial_bus_collision = r[BUS_COLL_BIT];
        return s;
    endfunction

endpackage

// *** design/pie_req_gate.sv ***
// request gating: flag and enable, plus rising-edge event per source
`timescale 1ns/1ps
module pie_req_gate (
    // clock and reset
    input  wire logic           core_clk,
    input  wire logic           resetn,
    // flags and enables
    input  wire pie_pkg::pie_src_t flags,
    input  wire pie_pkg::pie_src_t enables,
    // gated requests and their rising edges
    output pie_pkg::pie_src_t   gated,
    output pie_pkg::pie_src_t   rise
);
    import pie_pkg::*;

    pie_src_t prev;
    pie_src_t next_prev;

    // flag is only read, never modified here
    assign gated = flags & enables;
    assign rise  = gated & ~prev;

    always_comb begin
        next_prev = gated;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prev <= '0;
        end else begin
            prev <= next_prev;
        end
    end

endmodule

// *** design/pie_sticky.sv ***
// sticky status bits: set by events, cleared by software, set wins
`timescale 1ns/1ps
module pie_sticky #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         resetn,
    // set and clear strobes
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    // held bits
    output logic [W-1:0]      status
);
    logic [W-1:0] next_status;

    always_comb begin
        next_status = (status & ~clr) | set;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

endmodule

// *** design/pie_irq_enable_top.sv ***
// peripheral interrupt enable register with apb access and irq status
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - bit 5 gates the comparator request
// - bit 4 gates nvm write-done request
// - bit 3 gates serial bus-collision request
// - bits 6 and 2..0 always read zero
// - bit 7 gates the oscillator-fail request
module pie_irq_enable_top (
    // clock and reset
    input  wire logic                             core_clk,
    input  wire logic                             resetn,
    // apb slave
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [pie_pkg::PIE_ADDR_W-1:0]   paddr,
    input  wire logic [pie_pkg::PIE_DATA_W-1:0]   pwdata,
    output logic                                  pready,
    output logic [pie_pkg::PIE_DATA_W-1:0]        prdata,
    output logic                                  pslverr,
    // peripheral request flags
    input  wire pie_pkg::pie_src_t                periph_flags,
    // gated requests toward the core interrupt logic
    output pie_pkg::pie_src_t                     gated_req,
    // enable fields, as held
    output pie_pkg::pie_src_t                     irq_enable,
    // block interrupt
    output logic                                  irq
);
    import pie_pkg::*;

    // address decode, shared by read and write paths
    function automatic pie_sel_t decode(
        input logic [PIE_ADDR_W-1:0] addr
    );
        pie_sel_t s;
        if (addr == ENABLE_OFFSET) begin
            s = SEL_ENABLE;
        end else if (addr == LIVE_OFFSET) begin
            s = SEL_LIVE;
        end else if (addr == STATUS_OFFSET) begin
            s = SEL_STATUS;
        end else if (addr == CLEAR_OFFSET) begin
            s = SEL_CLEAR;
        end else if (addr == IRQ_EN_OFFSET) begin
            s = SEL_IRQ_EN;
        end else begin
            s = SEL_NONE;
        end
        return s;
    endfunction

    // widen an 8-bit register value onto the data bus
    function automatic logic [PIE_DATA_W-1:0] widen(
        input logic [PIE_REG_W-1:0] r
    );
        logic [PIE_DATA_W-1:0] d;
        d = '0;
        d[PIE_REG_W-1:0] = r & IMPL_MASK;
        return d;
    endfunction

    // bus phase terms
    logic     setup_phase;
    logic     write_done;
    pie_sel_t sel;

    // register state
    logic [PIE_REG_W-1:0]  enable_reg;
    logic [PIE_REG_W-1:0]  next_enable_reg;
    logic [PIE_REG_W-1:0]  irq_en_reg;
    logic [PIE_REG_W-1:0]  next_irq_en_reg;
    logic [PIE_DATA_W-1:0] next_prdata;
    logic                  next_pslverr;

    // interrupt status path
    pie_src_t             gated;
    pie_src_t             gated_rise;
    logic [PIE_REG_W-1:0] status_set;
    logic [PIE_REG_W-1:0] status_clr;
    logic [PIE_REG_W-1:0] status_reg;

    // slave answers without wait states
    assign pready      = 1'b1;
    assign setup_phase = psel & ~penable;
    assign write_done  = psel & penable & pready & pwrite;
    assign sel         = decode(paddr);

    // enable register writes; unused bit positions never hold a one
    always_comb begin
        next_enable_reg = enable_reg;
        if (write_done && sel == SEL_ENABLE) begin
            next_enable_reg = pwdata[PIE_REG_W-1:0] & IMPL_MASK;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            enable_reg <= ENABLE_RESET;
        end else begin
            enable_reg <= next_enable_reg;
        end
    end

    // field view of the enable register
    assign irq_enable = reg_to_src(enable_reg);

    // each source passes only while its enable bit is one
    pie_req_gate u_gate (
        .core_clk (core_clk),
        .resetn   (resetn),
        .flags    (periph_flags),
        .enables  (irq_enable),
        .gated    (gated),
        .rise     (gated_rise)
    );

    assign gated_req = gated;

    // interrupt enable register, same layout
    always_comb begin
        next_irq_en_reg = irq_en_reg;
        if (write_done && sel == SEL_IRQ_EN) begin
            next_irq_en_reg = pwdata[PIE_REG_W-1:0] & IMPL_MASK;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq_en_reg <= IRQ_EN_RESET;
        end else begin
            irq_en_reg <= next_irq_en_reg;
        end
    end

    // sticky status: a new gated request sets, write-one clears
    assign status_set = src_to_reg(gated_rise);

    always_comb begin
        status_clr = '0;
        if (write_done && sel == SEL_CLEAR) begin
            status_clr = pwdata[PIE_REG_W-1:0] & IMPL_MASK;
        end
    end

    pie_sticky #(
        .W (PIE_REG_W)
    ) u_status (
        .core_clk (core_clk),
        .resetn   (resetn),
        .set      (status_set),
        .clr      (status_clr),
        .status   (status_reg)
    );

    // level interrupt while any enabled status bit is set
    assign irq = |(status_reg & irq_en_reg & IMPL_MASK);

    // read data and error captured in the setup cycle
    always_comb begin
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (setup_phase) begin
            next_pslverr = 1'b0;
            next_prdata  = RDATA_RESET;
            if (sel == SEL_NONE) begin
                next_pslverr = 1'b1;
            end else if (!pwrite) begin
                if (sel == SEL_ENABLE) begin
                    next_prdata = widen(enable_reg);
                end else if (sel == SEL_LIVE) begin
                    next_prdata = widen(src_to_reg(gated));
                end else if (sel == SEL_STATUS) begin
                    next_prdata = widen(status_reg);
                end else if (sel == SEL_IRQ_EN) begin
                    next_prdata = widen(irq_en_reg);
                end else begin
                    next_prdata = RDATA_RESET;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= RDATA_RESET;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

endmodule

// *** verif/pie_irq_enable_top_chk.sv ***
// checker: port-level assertions for the irq enable block
`timescale 1ns/1ps
module pie_irq_enable_top_chk (
    // clock and reset
    input wire logic                           core_clk,
    input wire logic                           resetn,
    // apb
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic                           pwrite,
    input wire logic [pie_pkg::PIE_ADDR_W-1:0] paddr,
    input wire logic [pie_pkg::PIE_DATA_W-1:0] pwdata,
    input wire logic                           pready,
    input wire logic [pie_pkg::PIE_DATA_W-1:0] prdata,
    input wire logic                           pslverr,
    // sources
    input wire pie_pkg::pie_src_t              periph_flags,
    input wire pie_pkg::pie_src_t              gated_req,
    input wire pie_pkg::pie_src_t              irq_enable,
    input wire logic                           irq
);
    import pie_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_gate_comparator: assert property (
        gated_req.comparator == (periph_flags.comparator
        & irq_enable.comparator)) else $error("comparator gate wrong");
    a_gate_nvm_done: assert property (
        gated_req.nvm_write_done == (periph_flags.nvm_write_done
        & irq_enable.nvm_write_done)) else $error("nvm gate wrong");
    a_gate_bus_coll: assert property (
        gated_req.serial_bus_collision == (irq_enable.serial_bus_collision
        & periph_flags.serial_bus_collision)) else $error("coll gate wrong");
    a_gate_osc_fail: assert property (
        gated_req.osc_fail == (periph_flags.osc_fail & irq_enable.osc_fail))
        else $error("osc fail gate wrong");
    a_read_unused_zero: assert property (
        psel && penable && !pwrite |-> (prdata & ~32'h0000_00b8) == 32'h0)
        else $error("unused bits read nonzero");
    a_gate_and_only: assert property (
        gated_req == (periph_flags & irq_enable)) else $error("gate wrong");
    a_enable_write: assert property (
        psel && penable && pwrite && paddr == ENABLE_OFFSET |=> irq_enable
        == {$past(pwdata[7]), $past(pwdata[5]), $past(pwdata[4]),
        $past(pwdata[3])}) else $error("enable write not held");
    c_irq: cover property (irq);
    c_err: cover property (psel && penable && pslverr);
    c_wr: cover property (psel && penable && pwrite);
endmodule

bind pie_irq_enable_top pie_irq_enable_top_chk u_chk (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .periph_flags(periph_flags),
    .gated_req(gated_req), .irq_enable(irq_enable), .irq(irq)
);

// *** verif/pie_irq_enable_top_bench.sv ***
// testbench: apb driven checks of the irq enable block
`timescale 1ns/1ps
module pie_irq_enable_top_bench;
    import pie_pkg::*;
    logic                  core_clk, resetn, psel, penable, pwrite;
    logic                  pready, pslverr, irq, slv;
    logic [PIE_ADDR_W-1:0] paddr;
    logic [PIE_DATA_W-1:0] pwdata, prdata, rd;
    pie_src_t              periph_flags, gated_req, irq_enable;
    int                    num_errors, num_checks;
    logic [7:0]            pos [4] = '{8'h80, 8'h20, 8'h10, 8'h08};

    pie_irq_enable_top u_dut (.core_clk(core_clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .periph_flags(periph_flags),
        .gated_req(gated_req), .irq_enable(irq_enable), .irq(irq));

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        repeat (3000) @(posedge core_clk);
        num_errors++;
        results();
    end

    initial begin
        resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
        pwdata = '0; periph_flags = '0; num_errors = 0; num_checks = 0;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        apb(0, ENABLE_OFFSET, 0); chk(rd, 0);
        apb(0, IRQ_EN_OFFSET, 0); chk(rd, 0);
        apb(1, ENABLE_OFFSET, 32'hff);
        apb(0, ENABLE_OFFSET, 0); chk(rd, 32'hb8);
        $display("test reset and unused bits done");
        periph_flags <= 4'hf;
        for (int i = 0; i < 4; i++) begin
            apb(1, ENABLE_OFFSET, {24'h0, pos[i]});
            @(posedge core_clk);
            chk(32'(gated_req), 32'(4'h8 >> i));
            chk(32'(irq_enable), 32'(4'h8 >> i));
            apb(0, LIVE_OFFSET, 0); chk(rd, {24'h0, pos[i]});
        end
        apb(1, ENABLE_OFFSET, 0);
        @(posedge core_clk);
        chk(32'(gated_req), 0);
        chk(32'(periph_flags), 32'hf);
        // every source rose when periph_flags went high with all enables set, before the loop above
        apb(0, STATUS_OFFSET, 0); chk(rd, 32'hb8);
        apb(1, CLEAR_OFFSET, 32'hff);
        apb(0, STATUS_OFFSET, 0); chk(rd, 0);
        $display("test gating done");
        apb(1, IRQ_EN_OFFSET, 32'hff);
        apb(1, ENABLE_OFFSET, 32'h20);
        apb(0, STATUS_OFFSET, 0); chk(rd, 32'h20);
        chk(32'(irq), 1);
        apb(1, IRQ_EN_OFFSET, 0);
        @(posedge core_clk);
        chk(32'(irq), 0);
        apb(1, CLEAR_OFFSET, 32'h20);
        apb(0, STATUS_OFFSET, 0); chk(rd, 0);
        apb(0, 12'h100, 0); chk(rd, 0);
        chk(32'(slv), 1);
        $display("test status and errors done");
        results();
    end
endmodule
